// *** prsg_defs.vh ***
`ifndef PRSG_DEFS_VH
`define PRSG_DEFS_VH
// register byte offsets (word aligned)
`define PRSG_CTRL 8'h00
`define PRSG_STATUS 8'h04
`define PRSG_IRQ_STAT 8'h08
`define PRSG_IRQ_MASK 8'h0c
`define PRSG_CMPA_THR 8'h10
`define PRSG_CMPB_THR 8'h14
`define PRSG_START_NUM 8'h18
`define PRSG_NUMER 8'h1c
// segment table: base + 16*seg + 4*field
`define PRSG_SEG_BASE 8'h40
`define PRSG_SEG_F_LEN 2'd0
`define PRSG_SEG_F_INC 2'd1
`define PRSG_SEG_F_CFG 2'd2
// ctrl bits
`define PRSG_CTRL_RUN 0
`define PRSG_CTRL_CMPA_EN 1
`define PRSG_CTRL_CMPB_EN 2
`define PRSG_CTRL_MOD_CMPA 3
`define PRSG_CTRL_T1_CMPB 4
`define PRSG_CTRL_PM_EN 5
`define PRSG_CTRL_MASKA_LSB 8
`define PRSG_CTRL_MASKB_LSB 16
// segment cfg bits
`define PRSG_CFG_NEXT_LSB 0
`define PRSG_CFG_SLOW 4
`define PRSG_CFG_RST 5
`define PRSG_CFG_TRIG 6
`define PRSG_CFG_FLAG_LSB 8
// irq bits
`define PRSG_IRQ_CMPA 0
`define PRSG_IRQ_CMPB 1
`define PRSG_IRQ_SEG 2
`define PRSG_NSEG 8
`define PRSG_SLOW_DIV 2
`define PRSG_MAX_LEN 17'h10000
`endif

// *** prsg_seg_mem.v ***
`timescale 1ns/100ps
`default_nettype none
// small segment table, two registered read ports (bus and sequencer)
module prsg_seg_mem (
    // clock
    input wire clk,
    // write port
    input wire we,
    input wire [4:0] waddr,
    input wire [31:0] wdata,
    // read ports
    input wire [4:0] raddr_a,
    output reg [31:0] rdata_a,
    input wire [4:0] raddr_b,
    output reg [31:0] rdata_b
);
    reg [31:0] mem [0:31];

    // registered reads; no reset on storage, software loads it before run
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end
endmodule
`default_nettype wire

// *** prsg_ramp_gen.v ***
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "prsg_defs.vh"

// What this block does
// - eight programmable segments are chained through next-segment indices into one waveform.
// - a segment length counts up to 65536 update steps, a field of zero meaning 65536.
// - with a segment's slowdown bit set its increment is applied every second cycle.
// - an enabled comparator raises its flag while the numerator reaches its threshold.
// - comparator a may drive MOD_OUT (the modulation pin itself is never enabled) and comparator b trigger pin one.
// - comparator segment mask bit n enables monitoring in segment n, so 3 means 0 and 1.
// - each segment selects flag outputs that pulse on trigger pin two, and on pin one unless it is routed to comparator b, when it starts.
// - a segment may wait for a rising edge on the modulation pin to end and start the next.
// - a segment may reset the numerator to its start value when it is loaded.
module prsg_ramp_gen (
    // clock and reset
    input wire CLOCK,
    input wire RESET,
    // wishbone slave
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    output wire WB_ERR_O,
    // pins
    input wire MOD_IN,
    output reg MOD_OUT,
    output wire MOD_OE_N,
    output reg TRIGGER_PIN_ONE_OUT,
    output reg TRIGGER_PIN_TWO_OUT,
    // synthesizer side
    output reg [31:0] FRAC_NUM,
    output reg [3:0] SEG_INDEX,
    output wire IRQ
);
    // sequencer states: load and wait fetch length, increment and config in turn
    localparam ST_IDLE = 2'd0;
    localparam ST_LOAD = 2'd1;
    localparam ST_WAIT = 2'd2;
    localparam ST_RAMP = 2'd3;

    // software visible registers
    reg [31:0] ctrl_q;
    reg [31:0] irq_stat_q;
    reg [31:0] irq_mask_q;
    reg [31:0] thr_a_q;
    reg [31:0] thr_b_q;
    reg [31:0] start_q;

    // sequencer state
    reg [1:0] state_q;
    reg [2:0] seg_q;
    reg [1:0] fld_q;
    reg [16:0] len_left_q;
    reg slow_ph_q;
    reg [31:0] inc_q;
    reg [31:0] cfg_q;
    reg mod_d1_q;

    // comparator and pin state
    reg flag_a_q;
    reg flag_b_q;
    reg [1:0] seg_flags_q;
    reg seg_start_q;

    // bus decode
    wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire is_seg = WB_ADR_I >= `PRSG_SEG_BASE;
    wire [7:0] seg_off = WB_ADR_I - `PRSG_SEG_BASE;
    wire seg_hit = is_seg & ~seg_off[7] & (seg_off[3:2] != 2'd3) & ~WB_ADR_I[1] & ~WB_ADR_I[0];
    wire reg_hit = ~is_seg & (WB_ADR_I[7:5] == 3'd0) & (WB_ADR_I[1:0] == 2'b00);
    wire hit = seg_hit | reg_hit;
    wire wr = req & WB_WE_I & hit;
    // table read data: port a for the bus, port b for the sequencer
    wire [31:0] mem_rdata_a;
    wire [31:0] mem_rdata_b;
    wire [31:0] bmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    // memory write is word wide and lands with the ack edge; partial sel merges with zero
    wire mem_we = wr & seg_hit & ack_pend_q;
    wire [31:0] mem_wdata = WB_DAT_I & bmask;
    reg [31:0] reg_rd;
    reg ack_pend_q;
    reg err_q;

    // sequencer step and end conditions
    wire run = ctrl_q[`PRSG_CTRL_RUN];
    wire mod_rise = MOD_IN & ~mod_d1_q;
    wire step_now = ~cfg_q[`PRSG_CFG_SLOW] | slow_ph_q;
    wire seg_done = cfg_q[`PRSG_CFG_TRIG] ? mod_rise : (len_left_q == 17'd1 && step_now);
    // at a segment's end the table is read at the next index already, so the next
    // length stands in the load cycle instead of the old segment's one
    wire seg_jump = run & (state_q == ST_RAMP) & seg_done;
    wire [2:0] seg_rd = seg_jump ? cfg_q[`PRSG_CFG_NEXT_LSB +: 3] : seg_q;

    // sequencer reads table by {segment, field}
    prsg_seg_mem u_mem (
        .clk(CLOCK),
        .we(mem_we),
        .waddr(seg_off[6:2]),
        .wdata(mem_wdata),
        .raddr_a(seg_off[6:2]),
        .rdata_a(mem_rdata_a),
        .raddr_b({seg_rd, fld_q}),
        .rdata_b(mem_rdata_b)
    );

    // unmapped addresses are answered with err rather than ack
    assign WB_ERR_O = err_q;
    assign MOD_OE_N = 1'b1; // modulation pin is never driven; MOD_OUT carries comparator a only when routed
    assign IRQ = |(irq_stat_q & irq_mask_q);

    // register read mux
    always @* begin
        reg_rd = 32'h0;
        if (WB_ADR_I == `PRSG_CTRL) begin
            reg_rd = ctrl_q;
        end else if (WB_ADR_I == `PRSG_STATUS) begin
            reg_rd = {16'h0, 3'h0, seg_start_q, flag_b_q, flag_a_q, state_q, 5'h0, seg_q};
        end else if (WB_ADR_I == `PRSG_IRQ_STAT) begin
            reg_rd = irq_stat_q;
        end else if (WB_ADR_I == `PRSG_IRQ_MASK) begin
            reg_rd = irq_mask_q;
        end else if (WB_ADR_I == `PRSG_CMPA_THR) begin
            reg_rd = thr_a_q;
        end else if (WB_ADR_I == `PRSG_CMPB_THR) begin
            reg_rd = thr_b_q;
        end else if (WB_ADR_I == `PRSG_START_NUM) begin
            reg_rd = start_q;
        end else if (WB_ADR_I == `PRSG_NUMER) begin
            reg_rd = FRAC_NUM;
        end
    end

    // two-cycle ack, one-cycle err: table reads need one cycle for the registered memory
    always @(posedge CLOCK) begin
        if (RESET) begin
            ack_pend_q <= 1'b0;
            WB_ACK_O <= 1'b0;
            err_q <= 1'b0;
            WB_DAT_O <= 32'h0;
        end else begin
            WB_ACK_O <= 1'b0;
            err_q <= 1'b0;
            if (req & ~ack_pend_q & ~err_q & ~hit) begin
                err_q <= 1'b1;
            end else if (req & ~ack_pend_q & ~err_q) begin
                ack_pend_q <= 1'b1;
            end else if (ack_pend_q) begin
                ack_pend_q <= 1'b0;
                WB_ACK_O <= 1'b1;
                WB_DAT_O <= seg_hit ? mem_rdata_a : reg_rd;
            end
        end
    end

    // comparator flags delayed by one cycle to find their rising edges
    reg flag_a_d1_q;
    reg flag_b_d1_q;
    always @(posedge CLOCK) begin
        if (RESET) begin
            flag_a_d1_q <= 1'b0;
            flag_b_d1_q <= 1'b0;
        end else begin
            flag_a_d1_q <= flag_a_q;
            flag_b_d1_q <= flag_b_q;
        end
    end

    // interrupt sources: segment start and the rise of each comparator flag
    wire [2:0] irq_ev = {seg_start_q, flag_b_q & ~flag_b_d1_q, flag_a_q & ~flag_a_d1_q};
    // registers change on the edge that raises ack, so a write lands exactly once
    wire reg_wr = wr & reg_hit & ack_pend_q;
    wire wr_ctrl = reg_wr & (WB_ADR_I == `PRSG_CTRL);
    wire wr_mask = reg_wr & (WB_ADR_I == `PRSG_IRQ_MASK);
    wire wr_thr_a = reg_wr & (WB_ADR_I == `PRSG_CMPA_THR);
    wire wr_thr_b = reg_wr & (WB_ADR_I == `PRSG_CMPB_THR);
    wire wr_start = reg_wr & (WB_ADR_I == `PRSG_START_NUM);
    wire wr_stat = reg_wr & (WB_ADR_I == `PRSG_IRQ_STAT);
    wire [31:0] w1c = WB_DAT_I & bmask;

    // control word; byte lanes honoured so one mask may be updated alone
    always @(posedge CLOCK) begin
        if (RESET) begin
            ctrl_q <= 32'h0;
        end else if (wr_ctrl) begin
            ctrl_q <= (ctrl_q & ~bmask) | (WB_DAT_I & bmask);
        end
    end

    // interrupt mask, same layout as the status
    always @(posedge CLOCK) begin
        if (RESET) begin
            irq_mask_q <= 32'h0;
        end else if (wr_mask) begin
            irq_mask_q <= (irq_mask_q & ~bmask) | (WB_DAT_I & bmask);
        end
    end

    // comparator a threshold
    always @(posedge CLOCK) begin
        if (RESET) begin
            thr_a_q <= 32'h0;
        end else if (wr_thr_a) begin
            thr_a_q <= (thr_a_q & ~bmask) | (WB_DAT_I & bmask);
        end
    end

    // comparator b threshold
    always @(posedge CLOCK) begin
        if (RESET) begin
            thr_b_q <= 32'h0;
        end else if (wr_thr_b) begin
            thr_b_q <= (thr_b_q & ~bmask) | (WB_DAT_I & bmask);
        end
    end

    // numerator loaded at run start and by segments asking for a reset
    always @(posedge CLOCK) begin
        if (RESET) begin
            start_q <= 32'h0;
        end else if (wr_start) begin
            start_q <= (start_q & ~bmask) | (WB_DAT_I & bmask);
        end
    end

    // sticky status, write one to clear; an event in the clearing cycle survives
    always @(posedge CLOCK) begin
        if (RESET) begin
            irq_stat_q <= 32'h0;
        end else if (wr_stat) begin
            irq_stat_q <= (irq_stat_q & ~w1c) | {29'h0, irq_ev};
        end else begin
            irq_stat_q <= irq_stat_q | {29'h0, irq_ev};
        end
    end

    // sequencer: load len, inc, cfg of the current segment, then ramp
    always @(posedge CLOCK) begin
        if (RESET) begin
            state_q <= ST_IDLE;
            seg_q <= 3'd0;
            fld_q <= 2'd0;
            len_left_q <= 17'd0;
            slow_ph_q <= 1'b0;
            inc_q <= 32'h0;
            cfg_q <= 32'h0;
            mod_d1_q <= 1'b0;
            FRAC_NUM <= 32'h0;
            seg_start_q <= 1'b0;
            seg_flags_q <= 2'b00;
        end else begin
            mod_d1_q <= MOD_IN;
            seg_start_q <= 1'b0;
            if (!run) begin
                state_q <= ST_IDLE;
                seg_q <= 3'd0;
                fld_q <= 2'd0;
                seg_flags_q <= 2'b00;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        FRAC_NUM <= start_q;
                        fld_q <= `PRSG_SEG_F_INC;
                        state_q <= ST_LOAD;
                    end
                    ST_LOAD: begin
                        // length arrives first, then increment, then config
                        len_left_q <= (mem_rdata_b[15:0] == 16'h0) ? `PRSG_MAX_LEN
                                      : {1'b0, mem_rdata_b[15:0]};
                        fld_q <= `PRSG_SEG_F_CFG;
                        state_q <= ST_WAIT;
                    end
                    ST_WAIT: begin
                        if (fld_q == `PRSG_SEG_F_CFG) begin
                            inc_q <= mem_rdata_b;
                            fld_q <= `PRSG_SEG_F_LEN;
                        end else begin
                            cfg_q <= mem_rdata_b;
                            if (mem_rdata_b[`PRSG_CFG_RST]) FRAC_NUM <= start_q;
                            seg_flags_q <= mem_rdata_b[`PRSG_CFG_FLAG_LSB +: 2];
                            seg_start_q <= 1'b1;
                            slow_ph_q <= 1'b0;
                            state_q <= ST_RAMP;
                        end
                    end
                    ST_RAMP: begin
                        slow_ph_q <= ~slow_ph_q;
                        if (step_now) begin
                            FRAC_NUM <= FRAC_NUM + inc_q;
                            if (len_left_q > 17'd1) len_left_q <= len_left_q - 17'd1;
                        end
                        if (seg_done) begin
                            seg_q <= cfg_q[`PRSG_CFG_NEXT_LSB +: 3];
                            fld_q <= `PRSG_SEG_F_INC;
                            state_q <= ST_LOAD;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // comparators, masked per segment; both channels share one loop
    wire ramping = run & (state_q == ST_RAMP);
    wire up = ~inc_q[31]; // a falling segment looks for the threshold from above
    wire [63:0] thr_all = {thr_b_q, thr_a_q};
    wire [15:0] mask_all = ctrl_q[`PRSG_CTRL_MASKA_LSB +: 16];
    wire [1:0] cmp_en = {ctrl_q[`PRSG_CTRL_CMPB_EN], ctrl_q[`PRSG_CTRL_CMPA_EN]};
    wire [1:0] cmp_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
            wire [31:0] thr_g = thr_all[gi * 32 +: 32];
            wire [7:0] mask_g = mask_all[gi * 8 +: 8];
            wire reached = up ? (FRAC_NUM >= thr_g) : (FRAC_NUM <= thr_g);
            assign cmp_hit[gi] = cmp_en[gi] & ramping & mask_g[seg_q] & reached;
        end
    endgenerate

    // flags and pins registered so the pins never glitch
    always @(posedge CLOCK) begin
        if (RESET) begin
            flag_a_q <= 1'b0;
            flag_b_q <= 1'b0;
            MOD_OUT <= 1'b0;
            TRIGGER_PIN_ONE_OUT <= 1'b0;
            TRIGGER_PIN_TWO_OUT <= 1'b0;
            SEG_INDEX <= 4'h0;
        end else begin
            flag_a_q <= cmp_hit[0];
            flag_b_q <= cmp_hit[1];
            MOD_OUT <= ctrl_q[`PRSG_CTRL_MOD_CMPA] & flag_a_q;
            if (ctrl_q[`PRSG_CTRL_T1_CMPB]) begin
                TRIGGER_PIN_ONE_OUT <= flag_b_q;
            end else begin
                TRIGGER_PIN_ONE_OUT <= seg_start_q & seg_flags_q[0];
            end
            TRIGGER_PIN_TWO_OUT <= seg_start_q & seg_flags_q[1];
            SEG_INDEX <= {1'b0, seg_q};
        end
    end
endmodule
`default_nettype wire

// *** prsg_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
// bus and pin checks seen from the top ports only
module prsg_sva (
    // clock and reset
    input wire CLOCK,
    input wire RESET,
    // bus
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_ACK_O,
    input wire WB_ERR_O,
    // pins
    input wire MOD_OE_N,
    input wire [3:0] SEG_INDEX,
    input wire [31:0] FRAC_NUM,
    input wire IRQ
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // a new request, then its answer within the latency of the note
    sequence req_new;
        $rose(WB_CYC_I && WB_STB_I);
    endsequence
    sequence answer;
        ##[1:3] (WB_ACK_O || WB_ERR_O);
    endsequence
    AST_ANSWER: assert property (req_new |-> answer)
        else $error("bus request not answered");
    AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    AST_ERR_PULSE: assert property (WB_ERR_O |=> !WB_ERR_O)
        else $error("err longer than one cycle");
    AST_ANS_IN_REQ: assert property ((WB_ACK_O || WB_ERR_O) |-> WB_CYC_I && WB_STB_I)
        else $error("answer without request");
    AST_ONE_ANS: assert property (!(WB_ACK_O && WB_ERR_O))
        else $error("ack and err together");
    AST_MOD_INPUT: assert property (MOD_OE_N)
        else $error("modulation pin driven");
    AST_SEG_RANGE: assert property (SEG_INDEX < 4'h8)
        else $error("segment index out of range");
    // the first edge after release still shows the cleared state
    AST_RST_STATE: assert property ($fell(RESET) |-> FRAC_NUM == 32'h0 && SEG_INDEX == 4'h0 && !IRQ)
        else $error("outputs not cleared by reset");
endmodule
bind prsg_ramp_gen prsg_sva u_sva (.CLOCK(CLOCK), .RESET(RESET), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .MOD_OE_N(MOD_OE_N),
    .SEG_INDEX(SEG_INDEX), .FRAC_NUM(FRAC_NUM), .IRQ(IRQ));
`default_nettype wire

// *** prsg_host.sv ***
`timescale 1ns/100ps
`default_nettype none
// outside controller driving the modulation pin as a trigger
module prsg_host (
    // clock
    input wire logic clk,
    // request from the bench
    input wire logic go,
    // modulation pin
    output logic mod_pin
);
    logic [1:0] cnt_q = 2'h0;
    // a clean rising edge held two cycles so it cannot be missed
    always @(posedge clk) begin
        if (go)
            cnt_q <= 2'h2;
        else if (cnt_q != 2'h0)
            cnt_q <= cnt_q - 2'h1;
    end
    assign mod_pin = (cnt_q != 2'h0);
endmodule
`default_nettype wire

// *** prsg_ramp_gen_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "prsg_defs.vh"
module prsg_ramp_gen_tb;
    logic CLOCK = 1'b0;
    logic RESET = 1'b1;
    logic cyc, stb, we, go, a, b, c, d;
    logic [7:0] adr;
    logic [31:0] dat, st, r, f;
    wire [31:0] dat_o, frac;
    wire [3:0] seg;
    wire ack, err, mod_in, mod_out, oe_n, t1, t2, irq;
    int n_errors = 0;
    int checks = 0;
    int cyc_cnt = 0;
    logic [32:0] exp_q[$];
    prsg_ramp_gen DUT (.CLOCK(CLOCK), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .WB_ERR_O(err), .MOD_IN(mod_in), .MOD_OUT(mod_out), .MOD_OE_N(oe_n),
        .TRIGGER_PIN_ONE_OUT(t1), .TRIGGER_PIN_TWO_OUT(t2), .FRAC_NUM(frac), .SEG_INDEX(seg), .IRQ(irq));
    prsg_host u_host (.clk(CLOCK), .go(go), .mod_pin(mod_in));
    initial begin
        forever #2.5 CLOCK = ~CLOCK;
    end
    task check(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("checks=%0d errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one classic cycle, held until ack or err is sampled
    task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge CLOCK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        dat <= d;
        @(posedge CLOCK);
        while (!(ack || err)) @(posedge CLOCK);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rd(input logic [7:0] ad, input logic [32:0] e);
        exp_q.push_back(e);
        bus(1'b0, ad, 32'h0);
    endtask
    // fire a trigger, follow the ramp until it is back in segment 0
    task run_seg(output logic [31:0] fv, output logic t1s, t2s, ms, fast);
        logic s1;
        logic [31:0] p1, p2;
        go <= 1'b1;
        @(posedge CLOCK);
        go <= 1'b0;
        {s1, t1s, t2s, ms, fast} = 5'h0;
        p1 = frac;
        p2 = frac;
        for (int k = 0; k < 300 && !(s1 && seg == 4'h0); k++) begin
            @(posedge CLOCK);
            t1s |= t1;
            t2s |= t2;
            ms |= mod_out;
            fast |= (frac !== p1 && p1 !== p2 && seg == 4'h1);
            p2 = p1;
            p1 = frac;
            s1 |= (seg == 4'h1);
        end
        repeat (8) @(posedge CLOCK);
        fv = frac;
    endtask
    // result watcher and hang guard; data is ignored on err
    always @(posedge CLOCK) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 4000) begin
            n_errors++;
            end_of_test;
        end
        if ((ack && !we) || err)
            check(err ? 33'h100000000 : {1'b0, dat_o}, exp_q.pop_front());
    end
    initial begin
        {cyc, stb, we, go, adr, dat} = '0;
        void'($urandom(15));
        repeat (2) @(posedge CLOCK);
        RESET <= 1'b0;
        rd(`PRSG_CTRL, 33'h0);
        rd(`PRSG_STATUS, 33'h0);
        rd(`PRSG_NUMER, 33'h0);
        rd(8'h4c, 33'h100000000);
        $display("test reset_and_map done");
        r = $urandom_range(200, 1);
        st = $urandom & 32'hffff;
        bus(1'b1, `PRSG_START_NUM, st);
        bus(1'b1, 8'h40, 32'h1);
        bus(1'b1, 8'h44, 32'h0);
        bus(1'b1, 8'h48, 32'h41);
        bus(1'b1, 8'h50, 32'h4);
        bus(1'b1, 8'h54, r);
        bus(1'b1, 8'h58, 32'h310);
        bus(1'b1, `PRSG_CMPA_THR, st + r);
        bus(1'b1, `PRSG_IRQ_MASK, 32'h1);
        bus(1'b1, `PRSG_CTRL, 32'h30b);
        repeat (20) @(posedge CLOCK);
        check(seg, 33'h0);
        check(frac, st);
        run_seg(f, a, d, b, c);
        check(a, 33'h1);
        check(d, 33'h1);
        check(oe_n, 33'h1);
        check(b, 33'h1);
        check(c, 33'h0);
        check(f, st + 4 * r);
        check(irq, 33'h1);
        rd(`PRSG_IRQ_STAT, 33'h5);
        bus(1'b1, `PRSG_IRQ_STAT, 32'h7);
        @(posedge CLOCK);
        check(irq, 33'h0);
        bus(1'b1, 8'h48, 32'h61);
        run_seg(f, a, d, b, c);
        check(f, st);
        $display("test ramp done");
        end_of_test;
    end
endmodule
`default_nettype wire
